// [core/pea_regs.svh]
// Purpose: Constants for the page entry attribute logic
// Assumes: 64-bit entries, 52-bit physical address limit
// Notes: Included by both design modules
`ifndef PEA_REGS_SVH
`define PEA_REGS_SVH
`define PEA_BIT_PRESENT 0
`define PEA_BIT_WRITE 1
`define PEA_BIT_USER 2
`define PEA_BIT_THROUGH 3
`define PEA_BIT_INHIBIT 4
`define PEA_BIT_ACCESSED 5
`define PEA_BIT_DIRTY 6
`define PEA_BIT_SIZE 7
`define PEA_BIT_GLOBAL 8
`define PEA_BIT_ATTR_LEAF 7
`define PEA_BIT_ATTR_BIG 12
`define PEA_BIT_EXEC_FORBID 63
`define PEA_PA_WIDTH_EXT 52
`define PEA_PA_WIDTH_LEGACY 32
`define PEA_TOP_INDEX_HI 47
`define PEA_TOP_INDEX_LO 39
`define PEA_LOW_4K 12
`define PEA_LOW_2M 21
`define PEA_LOW_4M 22
`define PEA_LOW_1G 30
`define PEA_RMW_CYCLES 2
`endif

// [core/pea_pkg.sv]
// Purpose: Types shared by the entry decoder and its top
// Assumes: Nothing beyond the constants header
// Notes: Types only
package pea_pkg;
   typedef enum logic [1:0] {PEA_PG_4K, PEA_PG_2M, PEA_PG_4M, PEA_PG_1G} pea_size_type;
   typedef enum logic [1:0] {PEA_LVL_TOP, PEA_LVL_PTR, PEA_LVL_DIR, PEA_LVL_LEAF} pea_level_type;
   typedef enum {PEA_ST_IDLE, PEA_ST_READ, PEA_ST_WRITE} pea_state_type;
endpackage : pea_pkg

// [core/pea_dec_if.sv]
// Purpose: Carries one entry and mode into the decoder and its result back
// Assumes: Combinational path, same clock as the top
// Notes: Owner side drives entry and modes; decoder side drives results
`timescale 1ns/100ps
`default_nettype none
interface pea_dec_if;
   logic [63:0] entry;
   pea_pkg::pea_level_type level;
   logic ext_mode;
   logic long_mode;
   logic large_en;
   logic xf_enable;
   logic present;
   logic final_level;
   pea_pkg::pea_size_type size;
   logic [51:0] base;
   logic [2:0] attr_index;
   logic rsv_fault;
   logic exec_forbid;
   modport owner (output entry, level, ext_mode, long_mode, large_en, xf_enable,
                  input present, final_level, size, base, attr_index, rsv_fault, exec_forbid);
   modport decoder (input entry, level, ext_mode, long_mode, large_en, xf_enable,
                    output present, final_level, size, base, attr_index, rsv_fault, exec_forbid);
endinterface : pea_dec_if
`default_nettype wire

// [core/pea_entry_dec.sv]
// Purpose: Pure field decode of one translation entry
// Assumes: Entry is stable for the cycle
// Notes: Spare software bits are never looked at
`timescale 1ns/100ps
`default_nettype none
`include "pea_regs.svh"
module pea_entry_dec (
   pea_dec_if.decoder d
);
   logic [63:0] e;
   logic is_big;
   logic [51:0] raw;
   logic [51:0] mask;
   logic [63:0] rsv;
   logic has_xf;
   always_comb begin
      e = d.entry;
      d.present = e[`PEA_BIT_PRESENT];
      // Size bit only counts at directory or long-mode pointer level
      is_big = e[`PEA_BIT_SIZE] && ((d.level == pea_pkg::PEA_LVL_DIR && (d.ext_mode || d.large_en))
               || (d.level == pea_pkg::PEA_LVL_PTR && d.long_mode));
      d.final_level = is_big || d.level == pea_pkg::PEA_LVL_LEAF;
      if (d.level == pea_pkg::PEA_LVL_PTR && is_big)
         d.size = pea_pkg::PEA_PG_1G;
      else if (is_big && !d.ext_mode)
         d.size = pea_pkg::PEA_PG_4M;
      else if (is_big)
         d.size = pea_pkg::PEA_PG_2M;
      else
         d.size = pea_pkg::PEA_PG_4K;
      // Legacy entries only carry 32 address bits
      raw = d.ext_mode ? e[51:0] : {20'h00000, e[31:0]};
      mask = 52'hF_FFFF_FFFF_F000;
      // 4M legacy base sits in 31:22 only; high bits 20:13 are not address
      unique case (d.size)
         pea_pkg::PEA_PG_4K: mask = 52'hF_FFFF_FFFF_F000;
         pea_pkg::PEA_PG_2M: mask = 52'hF_FFFF_FFE0_0000;
         pea_pkg::PEA_PG_4M: mask = 52'hF_FFFF_FFC0_0000;
         pea_pkg::PEA_PG_1G: mask = 52'hF_FFFF_C000_0000;
      endcase
      d.base = raw & mask;
      d.attr_index = {(d.level == pea_pkg::PEA_LVL_LEAF) ? e[`PEA_BIT_ATTR_LEAF] :
                      (is_big ? e[`PEA_BIT_ATTR_BIG] : 1'b0),
                      e[`PEA_BIT_INHIBIT], e[`PEA_BIT_THROUGH]};
      // Legacy extended pointer entries carry no execute-forbid bit
      has_xf = d.ext_mode && !(d.level == pea_pkg::PEA_LVL_PTR && !d.long_mode);
      d.exec_forbid = has_xf && d.xf_enable && e[`PEA_BIT_EXEC_FORBID];
      // Reserved: bits between the base and the attribute bit in 2M and 1G pages
      rsv = 64'h0000_0000_0000_0000;
      if (is_big && d.size == pea_pkg::PEA_PG_2M)
         rsv[20:13] = e[20:13];
      if (is_big && d.size == pea_pkg::PEA_PG_1G)
         rsv[29:13] = e[29:13];
      if (d.ext_mode && (!d.xf_enable || !has_xf))
         rsv[`PEA_BIT_EXEC_FORBID] = e[`PEA_BIT_EXEC_FORBID];
      d.rsv_fault = d.present && (d.long_mode || (d.ext_mode && d.large_en)) && (rsv != 64'h0);
   end
endmodule : pea_entry_dec
`default_nettype wire

// [core/pea_top.sv]
// Purpose: Interprets a fetched entry, checks it, and writes flags back
// Assumes: Walker presents one entry per request; memory grants may come any number of cycles late
// Notes: Walk sequencing and the translation cache live elsewhere
//
`timescale 1ns/100ps
`default_nettype none
`include "pea_regs.svh"
module pea_top (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic ENTRY_VALID,
   input wire logic [63:0] ENTRY_DATA,
   input wire logic [1:0] ENTRY_LEVEL,
   input wire logic [47:0] VIRT_ADDR,
   input wire logic ACCESS_WRITE,
   input wire logic ACCESS_EXEC,
   input wire logic ACCESS_RETIRED,
   input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL,
   input wire logic ADDRESS_EXTENSION_MODE,
   input wire logic LONG_MODE_ACTIVE,
   input wire logic LARGE_PAGE_ENABLE,
   input wire logic EXEC_FORBID_ENABLE,
   input wire logic GLOBAL_PAGE_ENABLE,
   input wire logic [63:0] MEM_RDATA,
   input wire logic MEM_ACK,
   output logic MEM_LOCK,
   output logic MEM_REQ,
   output logic MEM_WE,
   output logic [63:0] MEM_WDATA,
   output logic RESULT_VALID,
   output logic PAGE_FAULT_EXCEPTION,
   output logic FAULT_PRIV,
   output logic FAULT_RSV,
   output logic FINAL_LEVEL,
   output logic [51:0] NEXT_BASE,
   output logic [1:0] PAGE_SIZE,
   output logic [2:0] ATTR_INDEX,
   output logic WRITE_THROUGH,
   output logic UNCACHEABLE,
   output logic CACHE_FILL,
   output logic KEEP_ON_ROOT_LOAD,
   output logic [8:0] TOP_INDEX
);
   // ******************************************************
   // Decoder hookup
   // ******************************************************
   pea_dec_if dif ();
   assign dif.entry = ENTRY_DATA;
   assign dif.level = pea_pkg::pea_level_type'(ENTRY_LEVEL);
   assign dif.ext_mode = ADDRESS_EXTENSION_MODE | LONG_MODE_ACTIVE;
   assign dif.long_mode = LONG_MODE_ACTIVE;
   assign dif.large_en = LARGE_PAGE_ENABLE;
   assign dif.xf_enable = EXEC_FORBID_ENABLE;
   pea_entry_dec u_dec (
      .d(dif.decoder)
   );

   // ******************************************************
   // State record
   // ******************************************************
   typedef struct packed {
      pea_pkg::pea_state_type st;
      logic [63:0] wdata;
      logic set_dirty;
      logic res_valid;
      logic fault;
      logic f_priv;
      logic f_rsv;
      logic final_lvl;
      logic [51:0] base;
      logic [1:0] size;
      logic [2:0] attr;
      logic wt;
      logic uc;
      logic fill;
      logic keep;
      logic [8:0] top_idx;
   } pea_state_rec_type;
   pea_state_rec_type s_r;
   pea_state_rec_type s_nxt;

   logic acc_ok;
   logic need_a;
   logic need_d;
   logic [63:0] merged;

   // Protection and flag needs for the entry now presented
   always_comb begin
      // A user access needs the user bit, a write needs the write bit
      acc_ok = (!ACCESS_WRITE || ENTRY_DATA[`PEA_BIT_WRITE])
               && (CURRENT_PRIVILEGE_LEVEL != 2'h3 || ENTRY_DATA[`PEA_BIT_USER])
               && (!ACCESS_EXEC || !dif.exec_forbid);
      need_a = !ENTRY_DATA[`PEA_BIT_ACCESSED];
      // Dirty only in final level, only for a retired write
      need_d = dif.final_level && ACCESS_WRITE && ACCESS_RETIRED
               && !ENTRY_DATA[`PEA_BIT_DIRTY];
   end

   // Fresh memory copy merged so software edits to other bits survive
   always_comb begin
      merged = MEM_RDATA;
      merged[`PEA_BIT_ACCESSED] = 1'b1;
      if (s_r.set_dirty)
         merged[`PEA_BIT_DIRTY] = 1'b1;
   end

   // ******************************************************
   // Next state
   // ******************************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.res_valid = 1'b0;
      unique case (s_r.st)
         pea_pkg::PEA_ST_IDLE: begin
            if (ENTRY_VALID) begin
               s_nxt.top_idx = VIRT_ADDR[`PEA_TOP_INDEX_HI:`PEA_TOP_INDEX_LO];
               if (!dif.present) begin
                  // Nothing else in the entry is looked at
                  s_nxt.res_valid = 1'b1;
                  s_nxt.fault = 1'b1;
                  s_nxt.f_priv = 1'b0;
                  s_nxt.f_rsv = 1'b0;
                  s_nxt.fill = 1'b0;
                  s_nxt.final_lvl = 1'b0;
                  s_nxt.keep = 1'b0;
               end else begin
                  s_nxt.f_priv = !acc_ok;
                  s_nxt.f_rsv = dif.rsv_fault;
                  s_nxt.fault = !acc_ok || dif.rsv_fault;
                  s_nxt.final_lvl = dif.final_level;
                  s_nxt.base = dif.base;
                  s_nxt.size = dif.size;
                  s_nxt.attr = dif.attr_index;
                  s_nxt.wt = ENTRY_DATA[`PEA_BIT_THROUGH];
                  s_nxt.uc = ENTRY_DATA[`PEA_BIT_INHIBIT];
                  s_nxt.keep = dif.final_level && ENTRY_DATA[`PEA_BIT_GLOBAL]
                               && GLOBAL_PAGE_ENABLE;
                  s_nxt.set_dirty = need_d && acc_ok && !dif.rsv_fault;
                  // A faulting entry is not marked and not cached
                  if (!(!acc_ok || dif.rsv_fault) && (need_a || need_d)) begin
                     s_nxt.st = pea_pkg::PEA_ST_READ;
                     s_nxt.fill = 1'b0;
                  end else begin
                     s_nxt.res_valid = 1'b1;
                     // Accessed already set, so the fill is safe now
                     s_nxt.fill = acc_ok && !dif.rsv_fault && dif.final_level;
                  end
               end
            end
         end
         pea_pkg::PEA_ST_READ: begin
            if (MEM_ACK) begin
               s_nxt.wdata = merged;
               s_nxt.st = pea_pkg::PEA_ST_WRITE;
            end
         end
         pea_pkg::PEA_ST_WRITE: begin
            if (MEM_ACK) begin
               s_nxt.st = pea_pkg::PEA_ST_IDLE;
               s_nxt.res_valid = 1'b1;
               s_nxt.fill = s_r.final_lvl;
               s_nxt.set_dirty = 1'b0;
            end
         end
      endcase
   end

   // ******************************************************
   // State register
   // ******************************************************
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_r <= '{st: pea_pkg::PEA_ST_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Lock held across read and write so the update is indivisible
   assign MEM_LOCK = (s_r.st != pea_pkg::PEA_ST_IDLE);
   assign MEM_REQ = (s_r.st != pea_pkg::PEA_ST_IDLE);
   assign MEM_WE = (s_r.st == pea_pkg::PEA_ST_WRITE);
   assign MEM_WDATA = s_r.wdata;
   assign RESULT_VALID = s_r.res_valid;
   assign PAGE_FAULT_EXCEPTION = s_r.fault;
   assign FAULT_PRIV = s_r.f_priv;
   assign FAULT_RSV = s_r.f_rsv;
   assign FINAL_LEVEL = s_r.final_lvl;
   assign NEXT_BASE = s_r.base;
   assign PAGE_SIZE = s_r.size;
   assign ATTR_INDEX = s_r.attr;
   assign WRITE_THROUGH = s_r.wt;
   assign UNCACHEABLE = s_r.uc;
   assign CACHE_FILL = s_r.fill & s_r.res_valid;
   assign KEEP_ON_ROOT_LOAD = s_r.keep;
   assign TOP_INDEX = s_r.top_idx;
endmodule : pea_top
`default_nettype wire

// [dv/pea_mem_model.sv]
// Purpose: Memory holding one table entry, as software left it
// Assumes: Grant given in the cycle of the request while slow is low
// Notes: Slow mode holds each grant back three cycles
`timescale 1ns/100ps
`default_nettype none
module pea_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req,
   input wire logic we,
   input wire logic set,
   input wire logic slow,
   input wire logic [63:0] wdata,
   input wire logic [63:0] set_data,
   output logic ack,
   output logic [63:0] rdata,
   output logic [63:0] mem_r
);
   logic [1:0] wait_r;
   // Grant, and read data only while granted
   assign ack = req && (!slow || wait_r == 2'h3);
   assign rdata = ack ? mem_r : ~mem_r; // Stale data would hide a late sample
   // Entry store; software preload wins over write back
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 2'h0;
         mem_r <= 64'h0;
      end else begin
         wait_r <= (req && !ack) ? wait_r + 2'h1 : 2'h0;
         if (set) mem_r <= set_data;
         else if (ack && we) mem_r <= wdata;
      end
   end
endmodule : pea_mem_model
`default_nettype wire

// [dv/pea_top_sva.sv]
// Purpose: Port checks of the entry logic
// Assumes: One clock, reset async low
// Notes: Bound to every pea_top below
`timescale 1ns/100ps
`default_nettype none
module pea_top_sva (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic ENTRY_VALID,
   input wire logic [63:0] ENTRY_DATA,
   input wire logic [63:0] MEM_RDATA,
   input wire logic MEM_ACK,
   input wire logic MEM_LOCK,
   input wire logic MEM_REQ,
   input wire logic MEM_WE,
   input wire logic [63:0] MEM_WDATA,
   input wire logic RESULT_VALID,
   input wire logic PAGE_FAULT_EXCEPTION,
   input wire logic FINAL_LEVEL,
   input wire logic [51:0] NEXT_BASE,
   input wire logic [1:0] PAGE_SIZE,
   input wire logic [2:0] ATTR_INDEX,
   input wire logic WRITE_THROUGH,
   input wire logic UNCACHEABLE,
   input wire logic CACHE_FILL
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // ****************
   // Steps of a request
   // ****************
   sequence s_np_take; ENTRY_VALID && !MEM_REQ && !ENTRY_DATA[0]; endsequence
   sequence s_rd_ack; MEM_REQ && !MEM_WE && MEM_ACK; endsequence
   sequence s_wr_ack; MEM_REQ && MEM_WE && MEM_ACK; endsequence
   property p_np; s_np_take |=> RESULT_VALID && PAGE_FAULT_EXCEPTION; endproperty
   property p_np_mem; s_np_take |=> !MEM_REQ && !CACHE_FILL; endproperty
   property p_rmw; s_rd_ack |=> MEM_WE && MEM_WDATA[5]
      && MEM_WDATA[63:7] == $past(MEM_RDATA[63:7]); endproperty
   property p_lock; MEM_REQ |-> MEM_LOCK; endproperty
   property p_done; s_wr_ack |=> RESULT_VALID && !MEM_REQ; endproperty
   property p_base; RESULT_VALID |-> NEXT_BASE[11:0] == 12'h000; endproperty
   property p_2m; RESULT_VALID && PAGE_SIZE == 2'h1 |-> NEXT_BASE[20:0] == 21'h0; endproperty
   property p_1g; RESULT_VALID && PAGE_SIZE == 2'h3 |-> NEXT_BASE[29:0] == 30'h0; endproperty
   property p_attr; RESULT_VALID |-> ATTR_INDEX[1:0] == {UNCACHEABLE, WRITE_THROUGH}; endproperty
   property p_fill; CACHE_FILL |-> RESULT_VALID && FINAL_LEVEL && !PAGE_FAULT_EXCEPTION;
   endproperty
   a_np: assert property (p_np) else $error("absent entry gave no fault");
   a_np_mem: assert property (p_np_mem) else $error("absent entry used");
   a_rmw: assert property (p_rmw) else $error("bad flag write back");
   a_lock: assert property (p_lock) else $error("unlocked update");
   a_done: assert property (p_done) else $error("no result after update");
   a_base: assert property (p_base) else $error("table base low bits");
   a_2m: assert property (p_2m) else $error("2M base low bits");
   a_1g: assert property (p_1g) else $error("1G base low bits");
   a_attr: assert property (p_attr) else $error("attribute index");
   a_fill: assert property (p_fill) else $error("bad cache fill");
endmodule : pea_top_sva
bind pea_top pea_top_sva u_sva (.*);
`default_nettype wire

// [dv/tb_pea_top.sv]
// Purpose: Directed entry cases against the entry logic
// Assumes: Mode bits held steady across a request
// Notes: Memory model holds the entry under test
`timescale 1ns/100ps
`default_nettype none
module tb_pea_top;
   logic CORE_CLK, RESET_N, ENTRY_VALID, ACCESS_WRITE, ACCESS_EXEC, ACCESS_RETIRED, slow;
   logic ADDRESS_EXTENSION_MODE, LONG_MODE_ACTIVE, LARGE_PAGE_ENABLE, EXEC_FORBID_ENABLE;
   logic GLOBAL_PAGE_ENABLE, MEM_ACK, MEM_LOCK, MEM_REQ, MEM_WE, RESULT_VALID, FAULT_PRIV;
   logic PAGE_FAULT_EXCEPTION, FAULT_RSV, FINAL_LEVEL, WRITE_THROUGH, UNCACHEABLE;
   logic CACHE_FILL, KEEP_ON_ROOT_LOAD;
   logic [1:0] ENTRY_LEVEL, CURRENT_PRIVILEGE_LEVEL, PAGE_SIZE;
   logic [2:0] ATTR_INDEX;
   logic [8:0] TOP_INDEX;
   logic [47:0] VIRT_ADDR;
   logic [51:0] NEXT_BASE;
   logic [63:0] ENTRY_DATA, MEM_RDATA, MEM_WDATA, mem_q;
   int errors = 0, total_checks = 0, cyc = 0;
   pea_top u_dut (.*);
   pea_mem_model u_mem (.clk(CORE_CLK), .rst_n(RESET_N), .req(MEM_REQ), .we(MEM_WE),
      .set(ENTRY_VALID), .slow(slow), .wdata(MEM_WDATA), .set_data(ENTRY_DATA),
      .ack(MEM_ACK), .rdata(MEM_RDATA), .mem_r(mem_q));
   // Clock, and a hang limit well past the longest run
   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end
   always @(posedge CORE_CLK) begin
      cyc++;
      if (cyc == 4000) begin
         errors++;
         end_sim();
      end
   end
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
      total_checks++;
      if (s !== x) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   // Mode bits {slow, ext, long, large, exec forbid, global}
   task automatic mode(input logic [5:0] m);
      @(posedge CORE_CLK);
      {slow, ADDRESS_EXTENSION_MODE, LONG_MODE_ACTIVE, LARGE_PAGE_ENABLE,
         EXEC_FORBID_ENABLE, GLOBAL_PAGE_ENABLE} <= m;
   endtask : mode
   // One entry; access kind k is {write, exec, retired, privilege level}
   task automatic go(input logic [63:0] e, input logic [1:0] lv, input logic [4:0] k);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      ENTRY_VALID <= 1'b1;
      ENTRY_DATA <= e;
      ENTRY_LEVEL <= lv;
      {ACCESS_WRITE, ACCESS_EXEC, ACCESS_RETIRED, CURRENT_PRIVILEGE_LEVEL} <= k;
      @(posedge CORE_CLK);
      ENTRY_VALID <= 1'b0;
      #1;
      while (RESULT_VALID !== 1'b1 && n < 20) begin
         @(posedge CORE_CLK);
         #1;
         n++;
      end
      chk("result", RESULT_VALID, 1'b1);
   endtask : go
   // Fault flags {fault, privilege, reserved} for one entry
   task automatic gf(input logic [63:0] e, input logic [4:0] k, input logic [2:0] x);
      go(e, 2'h3, k);
      chk("faults", {PAGE_FAULT_EXCEPTION, FAULT_PRIV, FAULT_RSV}, x);
   endtask : gf
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // ****************
   // Main sequence
   // ****************
   initial begin
      {RESET_N, ENTRY_VALID, ENTRY_DATA, ENTRY_LEVEL, ACCESS_WRITE, ACCESS_EXEC} = '0;
      {ACCESS_RETIRED, CURRENT_PRIVILEGE_LEVEL, slow, ADDRESS_EXTENSION_MODE} = '0;
      {LONG_MODE_ACTIVE, LARGE_PAGE_ENABLE, EXEC_FORBID_ENABLE, GLOBAL_PAGE_ENABLE} = '0;
      VIRT_ADDR = 48'hA5A5_1234_5678;
      repeat (16) @(posedge CORE_CLK);
      RESET_N <= 1'b1;
      mode(6'h1F);
      go(64'hFFFF_FFFF_FFFF_FFFE, 2'h3, 5'h17);
      chk("absent", {PAGE_FAULT_EXCEPTION, CACHE_FILL}, 2'b10);
      chk("absent mem", mem_q, 64'hFFFF_FFFF_FFFF_FFFE);
      mode(6'h3F);
      go(64'h800A_BCDE_F010_0F1F, 2'h3, 5'h17);
      chk("flags", mem_q, 64'h800A_BCDE_F010_0F7F);
      chk("page base", NEXT_BASE, 52'hA_BCDE_F010_0000);
      chk("attr", {ATTR_INDEX, WRITE_THROUGH, UNCACHEABLE, PAGE_SIZE}, 7'h3C);
      chk("fill", {CACHE_FILL, KEEP_ON_ROOT_LOAD, FINAL_LEVEL}, 3'h7);
      chk("top", TOP_INDEX, 9'h14B);
      mode(6'h1E);
      go(64'h800A_BCDE_F010_0F1F, 2'h3, 5'h13);
      chk("no dirty", mem_q, 64'h800A_BCDE_F010_0F3F);
      chk("keep", KEEP_ON_ROOT_LOAD, 1'b0);
      mode(6'h1F);
      gf(64'h800A_BCDE_F010_0F7D, 5'h17, 3'b110);
      gf(64'h800A_BCDE_F010_0F7B, 5'h03, 3'b110);
      gf(64'h800A_BCDE_F010_0F7B, 5'h00, 3'b000);
      gf(64'h800A_BCDE_F010_0F7F, 5'h08, 3'b110);
      go(64'h0000_0001_2340_30A3, 2'h2, 5'h00);
      chk("gap", {PAGE_FAULT_EXCEPTION, FAULT_RSV}, 2'b11);
      go(64'h0000_0001_2340_10A3, 2'h2, 5'h00);
      chk("2M base", NEXT_BASE, 52'h1_2340_0000);
      chk("2M", {ATTR_INDEX, PAGE_SIZE, FINAL_LEVEL}, 6'b100011);
      go(64'h0000_0040_4000_00A1, 2'h1, 5'h00);
      chk("1G", {NEXT_BASE, PAGE_SIZE}, {52'h40_4000_0000, 2'h3});
      mode(6'h19);
      gf(64'h800A_BCDE_F010_0F7F, 5'h00, 3'b101);
      mode(6'h04);
      go(64'h0000_0000_8BC0_10A3, 2'h2, 5'h00);
      chk("4M", {NEXT_BASE, PAGE_SIZE}, {52'h8BC0_0000, 2'h2});
      go(64'hFFFF_0000_1234_5061, 2'h2, 5'h00);
      chk("table", {NEXT_BASE, FINAL_LEVEL}, {52'h1234_5000, 1'b0});
      end_sim();
   end
endmodule : tb_pea_top
`default_nettype wire
